/* File: verilog/rsc_pkg.sv */
// Package with the register map, field layout, reset values and timing constants of the rail setpoint bank.
package rsc_pkg;

    // Register subaddresses.
    localparam logic [7:0] RSC_ADDR_BB_SETPOINT  = 8'h19;
    localparam logic [7:0] RSC_ADDR_CORE_RAMP    = 8'h1A;
    localparam logic [7:0] RSC_ADDR_LDO_SETPOINT = 8'h1B;

    // Reset values.
    localparam logic [7:0] RSC_RST_BB_SETPOINT  = 8'hB2;
    localparam logic [7:0] RSC_RST_CORE_RAMP    = 8'h06;
    localparam logic [7:0] RSC_RST_LDO_SETPOINT = 8'h1F;

    // Field positions.
    localparam int RSC_BB_PULSE_SKIP_BIT = 7;
    localparam int RSC_RAMP_TRIGGER_BIT  = 7;
    localparam int RSC_RAMP_BYPASS_BIT   = 6;
    localparam int RSC_VCODE_MSB         = 5;
    localparam int RSC_STEP_MSB          = 2;

    // Highest valid buck-boost code and the ramp code that means no stepping.
    localparam logic [5:0] RSC_BB_VCODE_MAX    = 6'h34;
    localparam logic [2:0] RSC_STEP_IMMEDIATE  = 3'h7;

    // Timing: clock period and the documented times, then cycle counts derived from them.
    localparam int RSC_CLK_PERIOD_NS = 10;
    localparam int RSC_BLANK_TIME_MS = 5;
    localparam int RSC_STEP_MAX_US   = 160;
    localparam int RSC_BLANK_CYC     = RSC_BLANK_TIME_MS * 1000000 / RSC_CLK_PERIOD_NS;
    localparam int RSC_STEP_MAX_CYC  = RSC_STEP_MAX_US * 1000 / RSC_CLK_PERIOD_NS;
    localparam int RSC_BLANK_W       = 19;
    localparam int RSC_STEP_W        = 14;

    // Number of core buck rails under ramp control.
    localparam int RSC_CORE_RAILS = 2;

    // Register access request from the serial management port.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rsc_req_s;

    // Voltage codes of the two core buck rails.
    typedef logic [RSC_CORE_RAILS-1:0][5:0] rsc_core_codes_t;

    // Ramp sequencer states, one-hot.
    typedef enum logic [1:0] {
        RSC_IDLE = 2'b01,
        RSC_RAMP = 2'b10
    } rsc_ramp_e;

endpackage : rsc_pkg

/* File: verilog/rsc_rail_setpoint_regs.sv */
// Register bank for the buck-boost and linear-regulator setpoints and the core buck ramp control.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Buck-boost setpoint at 0x19, reset B2, write-protected.
// - Buck-boost write blanks its monitors 5 ms.
// - Linear-regulator write blanks its monitors 5 ms.
// - Bit 7 selects light-load pulse skipping.
// - Bits 5..0 hold buck-boost code, reset 32h.
// - Resistor option may change power-up buck-boost code.
// - Ramp control at 0x1A, reset 06.
// - Ramping applies only to both core bucks.
// - Trigger write starts ramp; zero does nothing.
// - Trigger bit self-clears when transition finishes.
// - Bypass bit ramps on every setpoint update.
// - Step code 7 applies setpoint immediately.
// - Linear-regulator setpoint at 0x1B, reset 1F.
// - Linear code bits 5..0, bits 7..6 read zero.
module rsc_rail_setpoint_regs #(
    parameter int P_BLANK_CYC    = rsc_pkg::RSC_BLANK_CYC,
    parameter int P_STEP_MAX_CYC = rsc_pkg::RSC_STEP_MAX_CYC
) (
    input  wire logic                     i_mclk,
    input  wire logic                     i_sys_rst,
    input  wire rsc_pkg::rsc_req_s        i_req,
    input  wire logic                     i_prot_unlocked,
    input  wire logic                     i_bb_dflt_override,
    input  wire logic [5:0]               i_bb_dflt_code,
    input  wire rsc_pkg::rsc_core_codes_t i_core_target,
    input  wire logic                     i_core_set_upd,
    output logic [7:0]                    o_rdata,
    output logic                          o_rd_valid,
    output logic                          o_bb_pulse_skip,
    output logic [5:0]                    o_bb_vcode,
    output logic [5:0]                    o_ldo_vcode,
    output logic                          o_bb_blank,
    output logic                          o_ldo_blank,
    output rsc_pkg::rsc_core_codes_t      o_core_vcode,
    output logic                          o_ramp_busy
);
    import rsc_pkg::*;

    logic                   bb_pulse_skip_r;
    logic [5:0]             bb_vcode_r;
    logic [5:0]             ldo_vcode_r;
    logic                   trigger_r;
    logic                   bypass_r;
    logic [2:0]             step_sel_r;
    logic                   started_r;
    logic [RSC_BLANK_W-1:0] bb_blank_cnt_r;
    logic [RSC_BLANK_W-1:0] ldo_blank_cnt_r;
    logic [RSC_STEP_W-1:0]  step_cnt_r;
    logic [RSC_STEP_W-1:0]  step_len;
    rsc_ramp_e              state_r;
    rsc_core_codes_t        core_vcode_r;
    logic                   wr_bb;
    logic                   wr_bb_ok;
    logic                   wr_ramp;
    logic                   wr_ldo;
    logic                   ramp_start;
    logic                   at_target;
    logic                   step_due;
    logic [2:0]             step_code;
    logic [RSC_CORE_RAILS-1:0] rail_done;

    // Address decode of the write strobes.
    assign wr_bb    = i_req.wr && (i_req.addr == RSC_ADDR_BB_SETPOINT);
    assign wr_bb_ok = wr_bb && i_prot_unlocked;
    assign wr_ramp  = i_req.wr && (i_req.addr == RSC_ADDR_CORE_RAMP);
    assign wr_ldo   = i_req.wr && (i_req.addr == RSC_ADDR_LDO_SETPOINT);

    // A ramp starts on a trigger write of one, or on a setpoint update while the bypass is set.
    assign ramp_start = (wr_ramp && i_req.wdata[RSC_RAMP_TRIGGER_BIT])
                        || (bypass_r && i_core_set_upd);

    // A step code written together with the trigger must time the very first step.
    // Taking the stored code here would give one step of the old length.
    assign step_code = wr_ramp ? i_req.wdata[RSC_STEP_MSB:0] : step_sel_r;

    // Step length halves for each step code; code 6 gives one sixty-fourth of the longest step.
    assign step_len = RSC_STEP_W'(P_STEP_MAX_CYC >> step_code);
    assign step_due = (step_cnt_r == RSC_STEP_W'(1)) || (step_sel_r == RSC_STEP_IMMEDIATE);
    assign at_target = &rail_done;

    // Buck-boost setpoint; locked writes leave it untouched.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            bb_pulse_skip_r <= RSC_RST_BB_SETPOINT[RSC_BB_PULSE_SKIP_BIT];
            bb_vcode_r      <= RSC_RST_BB_SETPOINT[RSC_VCODE_MSB:0];
        end else if (!started_r && i_bb_dflt_override) begin
            bb_vcode_r <= i_bb_dflt_code;
        end else if (wr_bb_ok) begin
            bb_pulse_skip_r <= i_req.wdata[RSC_BB_PULSE_SKIP_BIT];
            bb_vcode_r      <= i_req.wdata[RSC_VCODE_MSB:0];
        end
    end

    // Start-up strap capture happens on the first edge after reset, not under the reset itself.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            started_r <= 1'b0;
        end else begin
            started_r <= 1'b1;
        end
    end

    // Linear-regulator setpoint; the two top bits are not stored at all.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ldo_vcode_r <= RSC_RST_LDO_SETPOINT[RSC_VCODE_MSB:0];
        end else if (wr_ldo) begin
            ldo_vcode_r <= i_req.wdata[RSC_VCODE_MSB:0];
        end
    end

    // Ramp control configuration fields.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            bypass_r   <= RSC_RST_CORE_RAMP[RSC_RAMP_BYPASS_BIT];
            step_sel_r <= RSC_RST_CORE_RAMP[RSC_STEP_MSB:0];
        end else if (wr_ramp) begin
            bypass_r   <= i_req.wdata[RSC_RAMP_BYPASS_BIT];
            step_sel_r <= i_req.wdata[RSC_STEP_MSB:0];
        end
    end

    // Trigger bit: a new start in the finishing cycle wins over the self-clear.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            trigger_r <= RSC_RST_CORE_RAMP[RSC_RAMP_TRIGGER_BIT];
        end else if (ramp_start) begin
            trigger_r <= 1'b1;
        end else if (state_r == RSC_RAMP && at_target) begin
            trigger_r <= 1'b0;
        end
    end

    // Ramp sequencer: idle until started, then steps the core rails until both reach target.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_r <= RSC_IDLE;
        end else begin
            case (state_r)
                RSC_IDLE: begin
                    if (ramp_start) begin
                        state_r <= RSC_RAMP;
                    end
                end
                RSC_RAMP: begin
                    if (at_target && !ramp_start) begin
                        state_r <= RSC_IDLE;
                    end
                end
                default: begin
                    state_r <= RSC_IDLE;
                end
            endcase
        end
    end

    // Step timer reloads on start and after every step.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            step_cnt_r <= '0;
        end else if (ramp_start || state_r != RSC_RAMP || step_due) begin
            step_cnt_r <= step_len;
        end else begin
            step_cnt_r <= step_cnt_r - RSC_STEP_W'(1);
        end
    end

    // Each core rail moves one code per step toward its stored setpoint, or straight to it under step code 7; other rails never ramp.
    generate
        for (genvar g = 0; g < RSC_CORE_RAILS; g++) begin : g_rail
            assign rail_done[g] = (core_vcode_r[g] == i_core_target[g]);
            always_ff @(posedge i_mclk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    core_vcode_r[g] <= '0;
                end else if (!started_r) begin
                    core_vcode_r[g] <= i_core_target[g];
                end else if (state_r == RSC_RAMP && step_sel_r == RSC_STEP_IMMEDIATE) begin
                    core_vcode_r[g] <= i_core_target[g];
                end else if (state_r == RSC_RAMP && step_due && !rail_done[g]) begin
                    if (core_vcode_r[g] < i_core_target[g]) begin
                        core_vcode_r[g] <= core_vcode_r[g] + 6'h01;
                    end else begin
                        core_vcode_r[g] <= core_vcode_r[g] - 6'h01;
                    end
                end
            end
        end
    endgenerate

    // Monitor blanking counters; a fresh write restarts the full window.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            bb_blank_cnt_r <= '0;
        end else if (wr_bb_ok) begin
            bb_blank_cnt_r <= RSC_BLANK_W'(P_BLANK_CYC);
        end else if (bb_blank_cnt_r != '0) begin
            bb_blank_cnt_r <= bb_blank_cnt_r - RSC_BLANK_W'(1);
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ldo_blank_cnt_r <= '0;
        end else if (wr_ldo) begin
            ldo_blank_cnt_r <= RSC_BLANK_W'(P_BLANK_CYC);
        end else if (ldo_blank_cnt_r != '0) begin
            ldo_blank_cnt_r <= ldo_blank_cnt_r - RSC_BLANK_W'(1);
        end
    end

    // Read data is registered; unmapped subaddresses return zero.
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rdata    <= 8'h00;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_req.rd;
            if (i_req.rd) begin
                case (i_req.addr)
                    RSC_ADDR_BB_SETPOINT:  o_rdata <= {bb_pulse_skip_r, 1'b0, bb_vcode_r};
                    RSC_ADDR_CORE_RAMP:    o_rdata <= {trigger_r, bypass_r, 3'h0, step_sel_r};
                    RSC_ADDR_LDO_SETPOINT: o_rdata <= {2'h0, ldo_vcode_r};
                    default:               o_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Outputs toward the regulators and monitors.
    assign o_bb_pulse_skip = bb_pulse_skip_r;
    assign o_bb_vcode      = bb_vcode_r;
    assign o_ldo_vcode     = ldo_vcode_r;
    assign o_bb_blank      = (bb_blank_cnt_r != '0);
    assign o_ldo_blank     = (ldo_blank_cnt_r != '0);
    assign o_core_vcode    = core_vcode_r;
    assign o_ramp_busy     = trigger_r;

    // Checks kept beside the logic.
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    sequence s_trig_write;
        wr_ramp && i_req.wdata[RSC_RAMP_TRIGGER_BIT];
    endsequence

    sequence s_bypass_update;
        bypass_r && i_core_set_upd && state_r == RSC_IDLE;
    endsequence

    AST_BB_LOCKED: assert property (wr_bb && !i_prot_unlocked && started_r |=> $stable(bb_vcode_r))
        else $error("Locked buck-boost write changed the setpoint.");

    AST_BB_BLANK: assert property (wr_bb_ok |=> o_bb_blank [*8])
        else $error("Buck-boost monitor not blanked after write.");

    AST_LDO_BLANK: assert property (wr_ldo |=> o_ldo_blank [*8])
        else $error("Linear-regulator monitor not blanked after write.");

    AST_RSV_ZERO: assert property (i_req.rd && i_req.addr == RSC_ADDR_LDO_SETPOINT |=> o_rdata[7:6] == 2'h0)
        else $error("Reserved linear-regulator bits read nonzero.");

    AST_TRIG_START: assert property (s_trig_write |=> trigger_r && state_r == RSC_RAMP)
        else $error("Trigger write did not start a ramp.");

    AST_BYPASS_START: assert property (s_bypass_update |=> state_r == RSC_RAMP)
        else $error("Setpoint update with bypass did not start a ramp.");

    AST_IMMEDIATE: assert property (s_trig_write ##1 (step_sel_r == RSC_STEP_IMMEDIATE && !ramp_start)
                                    |=> at_target)
        else $error("Immediate step code did not apply the setpoint at once.");

    AST_HOLD_BUSY: assert property (state_r == RSC_RAMP && !at_target |=> trigger_r)
        else $error("Trigger bit dropped before the transition finished.");

    AST_SELF_CLEAR: assert property (state_r == RSC_RAMP && at_target && !ramp_start |=> !trigger_r)
        else $error("Trigger bit did not clear at the end of the transition.");

    AST_ONE_STEP: assert property (state_r == RSC_RAMP && step_sel_r != RSC_STEP_IMMEDIATE && !step_due
                                   |=> $stable(core_vcode_r))
        else $error("Core rail moved between step ticks.");

    AST_NEED_TRIGGER: assert property (!bypass_r && i_core_set_upd && state_r == RSC_IDLE && !wr_ramp
                                       |=> state_r == RSC_IDLE)
        else $error("Setpoint update without bypass started a ramp.");

    AST_RAMP_SCOPE: assert property (state_r == RSC_RAMP && !wr_bb_ok && !wr_ldo
                                     |=> $stable(bb_vcode_r) && $stable(ldo_vcode_r))
        else $error("Ramp moved a rail outside the core bucks.");

endmodule : rsc_rail_setpoint_regs

`default_nettype wire

/* File: tb/rsc_host_model.sv */
// Host software model that issues register requests to the setpoint bank.
`timescale 1ns/10ps
`default_nettype none
module rsc_host_model (
    input  wire logic           i_mclk,
    input  wire logic           i_rd_valid,
    input  wire logic [7:0]     i_rdata,
    output var rsc_pkg::rsc_req_s o_req
);
    import rsc_pkg::*;
    // Requests change on the falling edge, so the bank samples settled values.
    initial o_req = '0;
    // One write; a reserved buck-boost code is never sent, it would give an undefined output.
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        if (addr == RSC_ADDR_BB_SETPOINT && data[5:0] > RSC_BB_VCODE_MAX) begin
            return;
        end
        @(negedge i_mclk);
        o_req = '{1'b1, 1'b0, addr, data};
        @(negedge i_mclk);
        o_req = '0;
    endtask : wr
    // One read; data and valid are taken in the cycle after the request edge.
    task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic vld);
        @(negedge i_mclk);
        o_req = '{1'b0, 1'b1, addr, 8'h00};
        @(negedge i_mclk);
        o_req = '0;
        vld = i_rd_valid;
        data = i_rdata;
    endtask : rd
endmodule : rsc_host_model
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the rail setpoint register bank.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import rsc_pkg::*;
    localparam int P_STEP = 64;
    logic            mclk = 1'b0;
    logic            sys_rst = 1'b1;
    logic            unlocked = 1'b0;
    logic            dflt_ovr = 1'b0;
    logic            set_upd = 1'b0;
    rsc_core_codes_t tgt = {6'h0A, 6'h14};
    rsc_req_s        req;
    rsc_core_codes_t core_v;
    logic [7:0]      rdata;
    logic [7:0]      d;
    logic [5:0]      bb_v;
    logic [5:0]      ldo_v;
    logic            rd_valid, bb_ps, bb_bl, ldo_bl, busy, v;
    int              failures = 0;
    int              cmp_count = 0;
    int              cycles = 0;
    int              n;

    // Free-running 100 MHz clock.
    always #5 mclk = ~mclk;

    rsc_rail_setpoint_regs #(.P_BLANK_CYC(20), .P_STEP_MAX_CYC(P_STEP)) rsc_rail_setpoint_regs_i (
        .i_mclk(mclk), .i_sys_rst(sys_rst), .i_req(req), .i_prot_unlocked(unlocked),
        .i_bb_dflt_override(dflt_ovr), .i_bb_dflt_code(6'h11), .i_core_target(tgt),
        .i_core_set_upd(set_upd), .o_rdata(rdata), .o_rd_valid(rd_valid), .o_bb_pulse_skip(bb_ps),
        .o_bb_vcode(bb_v), .o_ldo_vcode(ldo_v), .o_bb_blank(bb_bl), .o_ldo_blank(ldo_bl),
        .o_core_vcode(core_v), .o_ramp_busy(busy));

    rsc_host_model rsc_host_model_i (.i_mclk(mclk), .i_rd_valid(rd_valid), .i_rdata(rdata), .o_req(req));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        rsc_host_model_i.rd(a, d, v);
        chk({8'h00, d}, {8'h00, exp}, "read data");
        chk({15'h0, v}, 16'h1, "read valid");
    endtask : rchk

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // Hang guard; the whole sequence needs well under a thousand cycles.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            tally_and_finish();
        end
    end

    // Main sequence.
    initial begin
        repeat (16) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (2) @(negedge mclk);
        rchk(8'h19, 8'hB2);
        rchk(8'h1A, 8'h06);
        rchk(8'h1B, 8'h1F);
        rchk(8'h1C, 8'h00);
        $display("test reset values done");
        rsc_host_model_i.wr(8'h19, 8'h05);
        chk({15'h0, bb_bl}, 16'h0, "locked blank");
        rchk(8'h19, 8'hB2);
        unlocked = 1'b1;
        // The buck-boost converter is modelled as off here, so its code may be rewritten.
        rsc_host_model_i.wr(8'h19, 8'h74);
        chk({15'h0, bb_bl}, 16'h1, "bb blank");
        chk({15'h0, bb_ps}, 16'h0, "pulse skip");
        chk({10'h0, bb_v}, 16'h34, "bb code");
        repeat (17) @(negedge mclk);
        chk({15'h0, bb_bl}, 16'h1, "bb blank held");
        repeat (4) @(negedge mclk);
        chk({15'h0, bb_bl}, 16'h0, "bb blank end");
        rchk(8'h19, 8'h34);
        rsc_host_model_i.wr(8'h1B, 8'hE5);
        chk({15'h0, ldo_bl}, 16'h1, "ldo blank");
        chk({10'h0, ldo_v}, 16'h25, "ldo code");
        rchk(8'h1B, 8'h25);
        repeat (22) @(negedge mclk);
        chk({15'h0, ldo_bl}, 16'h0, "ldo blank end");
        $display("test setpoints done");
        rsc_host_model_i.wr(8'h1A, 8'h3E);
        chk({15'h0, busy}, 16'h0, "no trigger");
        rchk(8'h1A, 8'h06);
        // Each step code moves both rails one code; the ramp length shows the step time.
        for (int k = 0; k < 7; k++) begin
            tgt[0] = tgt[0] + 6'h01;
            // Core light-load bits live outside this bank and are held clear before lowering.
            tgt[1] = tgt[1] - 6'h01;
            rsc_host_model_i.wr(8'h1A, 8'h80 | 8'(k));
            chk({15'h0, busy}, 16'h1, "busy");
            n = 0;
            if (k == 0) begin
                rchk(8'h1A, 8'h80);
                n = 2;
            end
            while (busy === 1'b1 && n < 300) begin
                @(negedge mclk);
                n++;
            end
            chk({15'h0, n >= (P_STEP >> k) - 1 && n <= (P_STEP >> k) + 4}, 16'h1, "step time");
            chk({4'h0, core_v}, {4'h0, tgt}, "core code");
            chk({10'h0, bb_v}, 16'h34, "bb untouched");
        end
        tgt = {6'h20, 6'h05};
        rsc_host_model_i.wr(8'h1A, 8'h87);
        chk({15'h0, busy}, 16'h1, "busy");
        @(negedge mclk);
        chk({4'h0, core_v}, {4'h0, tgt}, "immediate");
        repeat (2) @(negedge mclk);
        chk({15'h0, busy}, 16'h0, "busy end");
        // With the bypass clear, a setpoint update alone must not start a ramp.
        set_upd = 1'b1;
        @(negedge mclk);
        set_upd = 1'b0;
        @(negedge mclk);
        chk({15'h0, busy}, 16'h0, "update needs trigger");
        $display("test ramp trigger done");
        rsc_host_model_i.wr(8'h1A, 8'h47);
        chk({15'h0, busy}, 16'h0, "bypass no start");
        @(negedge mclk);
        tgt = {6'h01, 6'h30};
        set_upd = 1'b1;
        @(negedge mclk);
        set_upd = 1'b0;
        chk({15'h0, busy}, 16'h1, "bypass start");
        @(negedge mclk);
        chk({4'h0, core_v}, {4'h0, tgt}, "bypass code");
        $display("test ramp bypass done");
        sys_rst = 1'b1;
        dflt_ovr = 1'b1;
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (2) @(negedge mclk);
        rchk(8'h19, 8'h91);
        rchk(8'h1A, 8'h06);
        $display("test strap reset done");
        tally_and_finish();
    end
endmodule : testbench
`default_nettype wire
